/* svfs_map.svh */
`ifndef SVFS_MAP_SVH
`define SVFS_MAP_SVH
`define SVFS_CLK_NS 8
`define SVFS_LOOP_NS 120000
`define SVFS_TICK_CYC (`SVFS_LOOP_NS / `SVFS_CLK_NS)
`define SVFS_OFF_CMD 11'h000
`define SVFS_OFF_P0 11'h004
`define SVFS_OFF_P1 11'h008
`define SVFS_OFF_P2 11'h00c
`define SVFS_OFF_STATUS 11'h010
`define SVFS_OFF_TARGET 11'h014
`define SVFS_OFF_VFF 11'h018
`define SVFS_OFF_FILT 11'h01c
`define SVFS_OFF_INCMD 11'h020
`define SVFS_DREG_BIT 10
`define SVFS_OP_REG_GEAR 8'hdf
`define SVFS_OP_IMM_GEAR 8'hb4
`define SVFS_OP_HALT 8'h03
`define SVFS_OP_TORQUE 8'hda
`define SVFS_OP_VELOCITY 8'hd9
`define SVFS_CPR_4000 16'h0fa0
`define SVFS_CPR_8000 16'h1f40
`define SVFS_UNITY_4000 16'h0400
`define SVFS_UNITY_8000 16'h0200
`define SVFS_UNITY_16000 16'h0100
`define SVFS_SFREG_MIN 8'h0a
`define SVFS_SFREG_MAX 8'hc7
`define SVFS_DECEL_MAX 32'h1fffffff
`define SVFS_INREG_CMD 8'h0c
`define SVFS_FILT_RST 8'h44
`endif

/* svfs_pkg.sv */
package svfs_pkg;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_GEAR = 3'b001,
		M_TORQUE = 3'b010,
		M_VEL = 3'b011,
		M_STOPPING = 3'b100
	} svfs_mode_t;
	typedef enum logic [1:0] {
		S_NONE = 2'b00,
		S_USE_ACCEL = 2'b01,
		S_GIVEN = 2'b10,
		S_IMMED = 2'b11
	} svfs_stop_kind_t;
	typedef struct packed {
		logic req;
		svfs_stop_kind_t kind;
		logic [31:0] decel;
	} svfs_stop_t;
	typedef struct packed {
		logic signed [31:0] num;
		logic [15:0] den;
	} svfs_ratio_t;
endpackage : svfs_pkg

/* svfs_lpf.sv */
`timescale 1ns/100ps
`default_nettype none
module svfs_lpf #(
	parameter int W = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic tick_i,
	input wire logic [3:0] shift_i,
	input wire logic signed [W-1:0] x_i,
	output logic signed [W-1:0] y_o
);
	// first-order section: y += (x - y) / 2^shift on each loop tick
	wire logic signed [W-1:0] diff = x_i - y_o;
	wire logic signed [W-1:0] step = diff >>> shift_i;
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			y_o <= '0;
		end else if (tick_i) begin
			y_o <= y_o + step;
		end
	end
endmodule : svfs_lpf
`default_nettype wire

/* svfs_gear.sv */
`timescale 1ns/100ps
`default_nettype none
module svfs_gear (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic master_step_i,
	input wire logic master_dir_i,
	input wire svfs_pkg::svfs_ratio_t ratio_i,
	output logic slave_step_o,
	output logic slave_dir_o
);
	// fractional accumulator: num per master count, one slave count per den
	logic signed [33:0] acc;
	wire logic signed [33:0] num = 34'(signed'(ratio_i.num));
	wire logic signed [33:0] den = {18'h0, ratio_i.den};
	wire logic signed [33:0] add = !master_step_i ? 34'sh0 : (master_dir_i ? -num : num);
	wire logic signed [33:0] sum = acc + add;
	wire logic up = (den != 34'sh0) && (sum >= den);
	wire logic dn = (den != 34'sh0) && (sum <= -den);
	wire logic signed [33:0] next_acc = up ? sum - den : (dn ? sum + den : sum);
	// one slave count per cycle at most; master edges are far slower
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			acc <= '0;
			slave_step_o <= 1'b0;
			slave_dir_o <= 1'b0;
		end else begin
			acc <= next_acc;
			slave_step_o <= up || dn;
			slave_dir_o <= dn;
		end
	end
endmodule : svfs_gear
`default_nettype wire

/* svfs_top.sv */
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "svfs_map.svh"
module svfs_top #(
	parameter int TICK_CYC = `SVFS_TICK_CYC,
	parameter logic [15:0] ENC_CPR = `SVFS_CPR_4000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [10:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic step_i,
	input wire logic dir_i,
	input wire logic [3:0] stop_in_i,
	input wire logic signed [31:0] actual_pos_i,
	input wire logic [31:0] accel_i,
	input wire logic motion_busy_i,
	input wire logic program_busy_i,
	input wire logic program_load_i,
	output logic signed [31:0] target_pos_o,
	output logic signed [31:0] vel_ff_o,
	output logic [2:0] loop_mode_o,
	output logic signed [31:0] input_cmd_o,
	output logic [15:0] input_filter_o,
	output svfs_pkg::svfs_stop_t stop_o,
	output logic program_abort_o,
	output logic program_clear_o,
	output logic cmd_ack_o,
	output logic cmd_nak_o
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : merge

	function automatic logic [15:0] unity(input logic [15:0] cpr);
		unity = (cpr == `SVFS_CPR_4000) ? `SVFS_UNITY_4000 :
			(cpr == `SVFS_CPR_8000) ? `SVFS_UNITY_8000 : `SVFS_UNITY_16000;
	endfunction : unity

	function automatic svfs_pkg::svfs_stop_kind_t decel_kind(input logic [31:0] d);
		decel_kind = d[31] ? svfs_pkg::S_IMMED :
			(d == 32'h00000000) ? svfs_pkg::S_USE_ACCEL : svfs_pkg::S_GIVEN;
	endfunction : decel_kind

	localparam logic [15:0] UNITY = unity(ENC_CPR);

	// pins cross into the clock domain through two flops each
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic step_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			step_d <= 1'b0;
		end else begin
			pin_s1 <= {stop_in_i, dir_i, step_i};
			pin_s2 <= pin_s1;
			step_d <= pin_s2[0];
		end
	end
	wire logic master_step = pin_s2[0] && !step_d;
	wire logic master_dir = pin_s2[1];
	wire logic [3:0] stop_pins = pin_s2[5:2];

	// register file
	logic [31:0] dreg [0:255];
	logic [31:0] p0;
	logic [31:0] p1;
	logic [31:0] p2;
	logic [7:0] last_op;
	logic [7:0] filt;
	logic [7:0] ack_cnt;
	logic nak;
	logic prog_valid;
	svfs_pkg::svfs_mode_t mode;
	logic gear_from_reg;
	logic [7:0] gear_idx;
	logic signed [15:0] gear_imm;
	logic [15:0] stop_en;
	logic [15:0] stop_state;

	wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic wb_wr = wb_req && wb_we_i;
	wire logic is_dreg = wb_adr_i[`SVFS_DREG_BIT];
	wire logic [7:0] dreg_idx = wb_adr_i[9:2];
	wire logic [10:0] off = {wb_adr_i[10:2], 2'b00};
	wire logic cmd_go = wb_wr && !is_dreg && off == `SVFS_OFF_CMD && wb_sel_i[0];
	wire logic [7:0] op = wb_dat_i[7:0];
	wire logic [31:0] status = {16'h0000, ack_cnt, 3'b000, prog_valid, nak, mode};

	wire logic [31:0] rd_reg =
		(off == `SVFS_OFF_CMD) ? {24'h000000, last_op} :
		(off == `SVFS_OFF_P0) ? p0 :
		(off == `SVFS_OFF_P1) ? p1 :
		(off == `SVFS_OFF_P2) ? p2 :
		(off == `SVFS_OFF_STATUS) ? status :
		(off == `SVFS_OFF_TARGET) ? target_pos_o :
		(off == `SVFS_OFF_VFF) ? vel_ff_o :
		(off == `SVFS_OFF_FILT) ? {24'h000000, filt} :
		(off == `SVFS_OFF_INCMD) ? input_cmd_o : 32'h00000000;
	wire logic [31:0] rd_data = is_dreg ? dreg[dreg_idx] : rd_reg;

	// every address answers in one cycle; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (wb_wr && is_dreg) begin
			dreg[dreg_idx] <= merge(dreg[dreg_idx], wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p0 <= '0;
			p1 <= '0;
			p2 <= '0;
			filt <= `SVFS_FILT_RST;
		end else if (wb_wr && !is_dreg) begin
			if (off == `SVFS_OFF_P0) p0 <= merge(p0, wb_dat_i, wb_sel_i);
			if (off == `SVFS_OFF_P1) p1 <= merge(p1, wb_dat_i, wb_sel_i);
			if (off == `SVFS_OFF_P2) p2 <= merge(p2, wb_dat_i, wb_sel_i);
			if (off == `SVFS_OFF_FILT && wb_sel_i[0]) filt <= wb_dat_i[7:0];
		end
	end

	// command decode and acceptance
	wire logic is_reg_gear = op == `SVFS_OP_REG_GEAR;
	wire logic is_imm_gear = op == `SVFS_OP_IMM_GEAR;
	wire logic is_halt = op == `SVFS_OP_HALT;
	wire logic is_torque = op == `SVFS_OP_TORQUE;
	wire logic is_vel = op == `SVFS_OP_VELOCITY;
	wire logic idx_ok = p0[31:8] == 24'h000000 && p0[7:0] >= `SVFS_SFREG_MIN && p0[7:0] <= `SVFS_SFREG_MAX;
	wire logic decel_ok = p0[31] || p0 <= `SVFS_DECEL_MAX;
	wire logic filt_ok = p0[31:15] == 17'h0;
	wire logic cmd_ok = (is_reg_gear && idx_ok) || is_imm_gear || (is_halt && decel_ok)
		|| ((is_torque || is_vel) && filt_ok);
	wire logic accept = cmd_go && cmd_ok;
	wire logic moving = mode != svfs_pkg::M_IDLE || motion_busy_i;
	wire svfs_pkg::svfs_stop_kind_t kind = decel_kind(p0);

	// stop-on-input: all enabled inputs at their requested state
	wire logic in_mode = mode == svfs_pkg::M_TORQUE || mode == svfs_pkg::M_VEL;
	wire logic pin_stop = in_mode && stop_en[3:0] != 4'h0
		&& ((stop_pins ^ stop_state[3:0]) & stop_en[3:0]) == 4'h0;

	wire svfs_pkg::svfs_mode_t next_mode =
		!accept ? mode :
		is_reg_gear ? svfs_pkg::M_GEAR :
		is_imm_gear ? svfs_pkg::M_GEAR :
		is_torque ? svfs_pkg::M_TORQUE :
		is_vel ? svfs_pkg::M_VEL :
		(moving && kind != svfs_pkg::S_IMMED) ? svfs_pkg::M_STOPPING : svfs_pkg::M_IDLE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= svfs_pkg::M_IDLE;
		end else if (accept) begin
			mode <= next_mode;
		end else begin
			case (mode)
				svfs_pkg::M_STOPPING: if (!motion_busy_i) mode <= svfs_pkg::M_IDLE;
				svfs_pkg::M_TORQUE, svfs_pkg::M_VEL: if (pin_stop) mode <= svfs_pkg::M_IDLE;
				default: mode <= mode;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gear_from_reg <= 1'b0;
			gear_idx <= '0;
			gear_imm <= '0;
			stop_en <= '0;
			stop_state <= '0;
			input_filter_o <= '0;
		end else if (accept) begin
			if (is_reg_gear) begin
				gear_from_reg <= 1'b1;
				gear_idx <= p0[7:0];
			end
			if (is_imm_gear) begin
				gear_from_reg <= 1'b0;
				gear_imm <= p0[15:0];
			end
			if (is_torque || is_vel) begin
				input_filter_o <= p0[15:0];
				stop_en <= p1[15:0];
				stop_state <= p2[15:0];
			end
		end
	end

	// acknowledge only, no payload; nak shows whether the last command written was refused
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_ack_o <= 1'b0;
			cmd_nak_o <= 1'b0;
			nak <= 1'b0;
			ack_cnt <= '0;
			last_op <= '0;
		end else begin
			cmd_ack_o <= accept;
			cmd_nak_o <= cmd_go && !cmd_ok;
			if (cmd_go) begin
				last_op <= op;
				nak <= !cmd_ok;
			end
			if (accept) ack_cnt <= ack_cnt + 8'h01;
		end
	end

	// halt: buffer always dropped, program aborted only when busy or not moving, motion per deceleration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_o <= '0;
			program_abort_o <= 1'b0;
			program_clear_o <= 1'b0;
			prog_valid <= 1'b0;
		end else begin
			stop_o.req <= accept && is_halt && moving;
			stop_o.kind <= (accept && is_halt && moving) ? kind : svfs_pkg::S_NONE;
			stop_o.decel <= (accept && is_halt && moving) ?
				((kind == svfs_pkg::S_USE_ACCEL) ? accel_i : p0) : 32'h00000000;
			program_abort_o <= accept && is_halt && (program_busy_i || !moving);
			program_clear_o <= accept && is_halt;
			if (program_load_i) begin
				prog_valid <= 1'b1;
			end else if (accept && is_halt) begin
				prog_valid <= 1'b0;
			end
		end
	end

	// gear ratio source: packed counts when the upper word is a legal master change
	wire logic [31:0] sf = dreg[gear_idx];
	wire logic packed_sf = !sf[31] && sf[30:16] != 15'h0;
	svfs_pkg::svfs_ratio_t ratio;
	assign ratio.num = !gear_from_reg ? 32'(gear_imm) :
		packed_sf ? 32'(signed'(sf[15:0])) : sf;
	assign ratio.den = (gear_from_reg && packed_sf) ? sf[31:16] : UNITY;

	wire logic following = mode == svfs_pkg::M_GEAR;
	logic slave_step;
	logic slave_dir;
	svfs_gear u_gear (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(following),
		.master_step_i(master_step),
		.master_dir_i(master_dir),
		.ratio_i(ratio),
		.slave_step_o(slave_step),
		.slave_dir_o(slave_dir)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			target_pos_o <= '0;
		end else if (accept && is_halt) begin
			target_pos_o <= actual_pos_i;
		end else if (following && slave_step) begin
			target_pos_o <= slave_dir ? target_pos_o - 32'sd1 : target_pos_o + 32'sd1;
		end
	end

	// loop-rate tick; master counts per tick feed the feedforward filters
	logic [$clog2(TICK_CYC)-1:0] tick_cnt;
	logic signed [15:0] mcount;
	wire logic tick = tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= '0;
			mcount <= '0;
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			if (tick) begin
				mcount <= '0;
			end else if (following && master_step) begin
				mcount <= master_dir ? mcount - 16'sd1 : mcount + 16'sd1;
			end
		end
	end

	// two cascaded sections take their shifts from the low and high nibbles of the filter register
	logic signed [31:0] vf1;
	wire logic signed [31:0] vin = {mcount, 16'h0000};
	svfs_lpf u_lpf1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!following),
		.tick_i(tick),
		.shift_i(filt[3:0]),
		.x_i(vin),
		.y_o(vf1)
	);
	svfs_lpf u_lpf2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(!following),
		.tick_i(tick),
		.shift_i(filt[7:4]),
		.x_i(vf1),
		.y_o(vel_ff_o)
	);

	// input modes: 12 command, 13/14 limits, 15 deadband, 16 centre,
	// 17 gain shift, 18 bit 0 inverts; limits assume 13 <= 14
	wire logic signed [31:0] r_cmd = dreg[`SVFS_INREG_CMD];
	wire logic signed [31:0] r_min = dreg[`SVFS_INREG_CMD + 8'h01];
	wire logic signed [31:0] r_max = dreg[`SVFS_INREG_CMD + 8'h02];
	wire logic signed [31:0] r_db = dreg[`SVFS_INREG_CMD + 8'h03];
	wire logic signed [31:0] r_ctr = dreg[`SVFS_INREG_CMD + 8'h04];
	wire logic [31:0] r_gain = dreg[`SVFS_INREG_CMD + 8'h05];
	wire logic [31:0] r_inv = dreg[`SVFS_INREG_CMD + 8'h06];
	wire logic signed [31:0] centred = (r_cmd - r_ctr) <<< r_gain[3:0];
	wire logic signed [31:0] signed_v = r_inv[0] ? -centred : centred;
	wire logic in_db = signed_v < r_db && signed_v > -r_db;
	wire logic signed [31:0] db_v = in_db ? 32'sd0 : signed_v;
	wire logic signed [31:0] clamp_v = db_v < r_min ? r_min : (db_v > r_max ? r_max : db_v);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_cmd_o <= '0;
		end else begin
			input_cmd_o <= in_mode ? clamp_v : 32'sd0;
		end
	end

	assign loop_mode_o = mode;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	a_wb_ack_answer: assert property (wb_req |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_cmd_ack_only: assert property (cmd_go && cmd_ok |=> cmd_ack_o && !cmd_nak_o)
		else $error("accepted command not acknowledged");
	a_reg_gear_mode: assert property (accept && is_reg_gear |=> mode == svfs_pkg::M_GEAR && gear_from_reg)
		else $error("register gearing not entered");
	a_imm_gear_mode: assert property (accept && is_imm_gear |=> following && gear_imm == $past(p0[15:0]))
		else $error("immediate gearing factor not taken");
	a_imm_unity: assert property (following && !gear_from_reg |-> ratio.den == UNITY)
		else $error("immediate ratio without unity factor");
	a_halt_target: assert property (accept && is_halt |=> target_pos_o == $past(actual_pos_i))
		else $error("halt did not load actual position");
	a_halt_clear: assert property (accept && is_halt && !program_load_i |=> program_clear_o && !prog_valid)
		else $error("halt did not clear program");
	a_halt_immed: assert property (accept && is_halt && p0[31] |=> mode == svfs_pkg::M_IDLE)
		else $error("immediate halt left motion running");
	a_halt_idle: assert property (accept && is_halt && !moving |=> program_abort_o ##1 !program_abort_o)
		else $error("idle halt did not abort program once");
	a_torque_mode: assert property (accept && is_torque |=> mode == svfs_pkg::M_TORQUE)
		else $error("torque input mode not entered");
	a_vel_mode: assert property (accept && is_vel |=> mode == svfs_pkg::M_VEL)
		else $error("velocity input mode not entered");
	a_ff_idle: assert property (!following |=> vel_ff_o == 32'sd0)
		else $error("feedforward active outside following");

	c_gear_step: cover property (following && slave_step ##1 target_pos_o != $past(target_pos_o));
	c_halt_decel: cover property (accept && is_halt && moving ##1 mode == svfs_pkg::M_STOPPING);
	c_pin_exit: cover property (in_mode && pin_stop ##1 mode == svfs_pkg::M_IDLE);
endmodule : svfs_top
`default_nettype wire

/* svfs_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module svfs_partner (
	input wire logic clk_i,
	input wire logic signed [31:0] target_pos_i,
	output logic signed [31:0] actual_pos_o,
	output logic step_o,
	output logic dir_o
);
	initial begin
		actual_pos_o = 32'sh0;
		step_o = 1'b0;
		dir_o = 1'b0;
	end
	// the shaft trails the target by one count a cycle, so a halt never sees actual equal to target for free
	always @(posedge clk_i) begin
		if (target_pos_i > actual_pos_o)
			actual_pos_o <= actual_pos_o + 32'sh1;
		else if (target_pos_i < actual_pos_o)
			actual_pos_o <= actual_pos_o - 32'sh1;
	end
	// direction settles two cycles ahead of the rising step so both sync chains agree
	task automatic send_steps(input int n, input logic d);
		@(posedge clk_i);
		dir_o <= d;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			step_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			step_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask : send_steps
endmodule : svfs_partner
`default_nettype wire

/* svfs_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module svfs_top_test;
	typedef struct {logic [7:0] op; logic [31:0] p0; logic busy; logic prog; logic ok; logic [2:0] mode; logic [1:0] kind;} svfs_row_t;
	localparam logic [31:0] ACCEL = 32'h1234;
	svfs_row_t rows [16] = '{
		'{8'hdf, 32'hb, 1'b0, 1'b0, 1'b1, 3'h1, 2'h0}, '{8'hdf, 32'h9, 1'b0, 1'b0, 1'b0, 3'h1, 2'h0},
		'{8'hdf, 32'hc8, 1'b0, 1'b0, 1'b0, 3'h1, 2'h0}, '{8'hdf, 32'hc7, 1'b0, 1'b0, 1'b1, 3'h1, 2'h0},
		'{8'hb4, 32'hfc00, 1'b0, 1'b0, 1'b1, 3'h1, 2'h0}, '{8'hda, 32'h7530, 1'b0, 1'b0, 1'b1, 3'h2, 2'h0},
		'{8'hda, 32'h8000, 1'b0, 1'b0, 1'b0, 3'h2, 2'h0}, '{8'hd9, 32'h0, 1'b0, 1'b0, 1'b1, 3'h3, 2'h0},
		'{8'h55, 32'h0, 1'b0, 1'b0, 1'b0, 3'h3, 2'h0}, '{8'hb4, 32'h400, 1'b0, 1'b0, 1'b1, 3'h1, 2'h0},
		'{8'h03, 32'h20000000, 1'b1, 1'b0, 1'b0, 3'h1, 2'h0}, '{8'h03, 32'h0, 1'b1, 1'b0, 1'b1, 3'h4, 2'h1},
		'{8'hdf, 32'ha, 1'b0, 1'b0, 1'b1, 3'h1, 2'h0}, '{8'h03, 32'h1fffffff, 1'b1, 1'b1, 1'b1, 3'h4, 2'h2},
		'{8'h03, 32'hffffffff, 1'b1, 1'b0, 1'b1, 3'h0, 2'h3}, '{8'h03, 32'h0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h0}};
	logic [31:0] ireg [7] = '{32'h64, 32'hfffffc18, 32'h3e8, 32'h0, 32'h28, 32'h1, 32'h0};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [10:0] wb_adr_i = 11'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [3:0] stop_in_i = 4'h0;
	logic [31:0] accel_i = ACCEL;
	logic motion_busy_i = 1'b0;
	logic program_busy_i = 1'b0;
	logic program_load_i = 1'b0;
	logic step_i, dir_i, wb_ack_o, program_abort_o, program_clear_o, cmd_ack_o, cmd_nak_o;
	logic g_ack, g_nak, g_abort, g_clear;
	logic [31:0] wb_dat_o, rdata;
	logic signed [31:0] actual_pos_i, target_pos_o, vel_ff_o, input_cmd_o, taken_pos, t0, g_target;
	logic [2:0] loop_mode_o, g_mode;
	logic [15:0] input_filter_o;
	svfs_pkg::svfs_stop_t stop_o, g_stop;
	int miscompares = 0;
	int total_checks = 0;
	int n;
	always #4 clk_i = ~clk_i;
	svfs_top #(.TICK_CYC(8), .ENC_CPR(16'h0fa0)) svfs_top_inst (
		.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
		.step_i, .dir_i, .stop_in_i, .actual_pos_i, .accel_i, .motion_busy_i, .program_busy_i, .program_load_i,
		.target_pos_o, .vel_ff_o, .loop_mode_o, .input_cmd_o, .input_filter_o, .stop_o, .program_abort_o,
		.program_clear_o, .cmd_ack_o, .cmd_nak_o);
	svfs_partner svfs_partner_inst (.clk_i, .target_pos_i(target_pos_o), .actual_pos_o(actual_pos_i),
		.step_o(step_i), .dir_o(dir_i));
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t: %s", $time, m);
		end
	endtask : chk
	// outputs are read in the active region after the edge, so they still hold what the previous edge registered
	task automatic bus(input logic [10:0] a, input logic we, input logic [31:0] d);
		int k;
		k = 0;
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		@(posedge clk_i);
		taken_pos = actual_pos_i;
		while (wb_ack_o !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		chk(k < 20, "no bus answer");
		rdata = wb_dat_o;
		g_ack = cmd_ack_o;
		g_nak = cmd_nak_o;
		g_stop = stop_o;
		g_abort = program_abort_o;
		g_clear = program_clear_o;
		g_mode = loop_mode_o;
		g_target = target_pos_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic gear(input logic [7:0] op, input logic [31:0] p, input logic d, input int e);
		bus(11'h4, 1'b1, p);
		bus(11'h0, 1'b1, {24'h0, op});
		t0 = target_pos_o;
		svfs_partner_inst.send_steps(12, d);
		repeat (12) @(posedge clk_i);
		chk(target_pos_o - t0 === 32'(e), "follower count");
		$display("gear test done");
	endtask : gear
	task automatic wait_cmd(input logic signed [31:0] v);
		n = 0;
		while (input_cmd_o !== v && n < 200) begin
			@(posedge clk_i);
			n++;
		end
	endtask : wait_cmd
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(11'h1c, 1'b0, 32'h0);
		chk(rdata === 32'h44 && loop_mode_o === 3'h0 && target_pos_o === 32'sh0, "reset state");
		bus(11'h7c, 1'b0, 32'h0);
		chk(rdata === 32'h0, "unmapped read");
		bus(11'h42c, 1'b1, 32'h800);
		bus(11'h428, 1'b1, 32'h400);
		bus(11'h71c, 1'b1, 32'h400);
		foreach (rows[i]) begin
			motion_busy_i <= rows[i].busy;
			program_busy_i <= rows[i].prog;
			bus(11'h4, 1'b1, rows[i].p0);
			bus(11'h0, 1'b1, {24'h0, rows[i].op});
			chk(g_ack === rows[i].ok && g_nak === !rows[i].ok && rdata === 32'h0, "command answer");
			chk(g_mode === rows[i].mode, "mode after command");
			chk(g_stop.req === (rows[i].kind != 2'h0) && (rows[i].kind == 2'h0 || g_stop.kind === rows[i].kind), "stop kind");
			if (rows[i].kind == 2'h1)
				chk(g_stop.decel === ACCEL, "reused accel");
			if (rows[i].kind == 2'h2)
				chk(g_stop.decel === rows[i].p0, "given decel");
			if (rows[i].op == 8'h03 && rows[i].ok) begin
				chk(g_clear === 1'b1 && g_target === taken_pos, "halt clear and target");
				chk(g_abort === (rows[i].prog || rows[i].kind == 2'h0), "program abort");
			end
			$display("row %0d done", i);
		end
		gear(8'hdf, 32'hb, 1'b0, 24);
		chk(vel_ff_o !== 32'sh0, "feedforward follows master");
		bus(11'h450, 1'b1, 32'h00030001);
		bus(11'h454, 1'b1, 32'h0002ffff);
		gear(8'hdf, 32'h14, 1'b0, 4);
		gear(8'hdf, 32'h15, 1'b0, -6);
		gear(8'hb4, 32'h400, 1'b0, 12);
		gear(8'hb4, 32'hfc00, 1'b0, -12);
		gear(8'hb4, 32'h400, 1'b1, -12);
		foreach (ireg[i])
			bus(11'h430 + 11'(4 * i), 1'b1, ireg[i]);
		bus(11'h8, 1'b1, 32'h1);
		bus(11'hc, 1'b1, 32'h1);
		bus(11'h4, 1'b1, 32'h7530);
		bus(11'h0, 1'b1, 32'hda);
		wait_cmd(32'sd120);
		chk(input_cmd_o === 32'sd120 && input_filter_o === 16'h7530, "torque processing");
		chk(vel_ff_o === 32'sh0, "feedforward cleared");
		stop_in_i <= 4'h1;
		n = 0;
		while (loop_mode_o !== 3'h0 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		chk(loop_mode_o === 3'h0, "input stop");
		stop_in_i <= 4'h0;
		bus(11'h448, 1'b1, 32'h1);
		bus(11'h8, 1'b1, 32'h0);
		bus(11'h4, 1'b1, 32'h64);
		bus(11'h0, 1'b1, 32'hd9);
		wait_cmd(-32'sd120);
		chk(input_cmd_o === -32'sd120 && loop_mode_o === 3'h3, "velocity processing");
		program_load_i <= 1'b1;
		@(posedge clk_i);
		program_load_i <= 1'b0;
		bus(11'h10, 1'b0, 32'h0);
		chk(rdata[4] === 1'b1, "program loaded");
		bus(11'h4, 1'b1, 32'h0);
		bus(11'h0, 1'b1, 32'h3);
		bus(11'h10, 1'b0, 32'h0);
		chk(rdata[4] === 1'b0 && rdata[3] === 1'b0 && rdata[2:0] === 3'h0, "program buffer cleared");
		bus(11'h0, 1'b0, 32'h0);
		chk(rdata === 32'h3, "last opcode");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(loop_mode_o === 3'h0 && target_pos_o === 32'sh0 && stop_o.req === 1'b0, "second reset");
		final_report();
	end
	// the whole sequence needs well under two thousand cycles
	initial begin
		repeat (8000) @(posedge clk_i);
		miscompares++;
		final_report();
	end
endmodule : svfs_top_test
`default_nettype wire
